/* File: verilog/fog_gpio_ctrl.sv */
// Function
// - Both pins start as fail outputs
// - Wake pins latch events like dedicated wake pins
// - GPIO pin level shown in normal, stop
// - Level also reported for switch roles
// - Pulsed pin level bit doubles as test
// - Function settings change only in normal mode
// - Stop, sleep keep last normal-mode configuration
// - Fail role drives on restart/fail-safe failure
// - Wake stays in restart, off in fail-safe
// - Wake resumes after restart, config untouched
// - Switches off in restart and fail-safe
// - Switches resume after restart, config untouched
// - Fail output stays active into normal mode
// - Indicator toggles 1.25 Hz, 50 percent
// - Pulsed output 100 Hz, selectable duty
// - Test input filtered 64 us
// - Force bit activates fail outputs for test
// - Duty choices 20/10/5/2.5, default 20
`timescale 1ns/1ns
`include "fog_defines.svh"
module fog_gpio_ctrl
  import fog_pkg::*;
#(
  parameter int unsigned IND_HALF_CYCLES   = `FOG_IND_HALF_CYCLES,
  parameter int unsigned PUL_PERIOD_CYCLES = `FOG_PUL_PERIOD_CYCLES,
  parameter int unsigned FILT_CYCLES       = `FOG_FILT_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // System state
  input  fog_mode_t        powerMode,
  input  wire logic        failActive,
  // Indicator pin
  input  wire logic        indPinIn,
  output logic             indPinOut,
  output logic             indPinOeN,
  // Pulsed / test pin
  input  wire logic        pulsedPinIn,
  output logic             pulsedPinOut,
  output logic             pulsedPinOeN
);

  typedef struct packed {
    fog_bus_t        busState;
    logic            waitrequest;
    logic [31:0]     readdata;
    logic [1:0][2:0] func;
    logic            failForce;
    logic [1:0]      duty;
    logic [1:0]      wakeStat;
    logic [1:0]      lvlStat;
    logic [1:0]      prevLvl;
    logic [25:0]     indCnt;
    logic            indPhase;
    logic [19:0]     pulCnt;
    logic [1:0]      pinOut;
    logic [1:0]      pinOeN;
  } fog_state_t;

  localparam fog_state_t ST_RST = '{
    busState:    FOG_BUS_IDLE,
    waitrequest: 1'b1,
    readdata:    32'h00000000,
    func:        {`FOG_RST_FUNC, `FOG_RST_FUNC},
    failForce:   `FOG_RST_FORCE,
    duty:        `FOG_RST_DUTY,
    wakeStat:    2'h0,
    lvlStat:     `FOG_RST_LEVEL,
    prevLvl:     `FOG_RST_LEVEL,
    indCnt:      26'h0000000,
    indPhase:    1'b1,
    pulCnt:      20'h00000,
    pinOut:      2'h0,
    pinOeN:      2'h3
  };

  localparam logic [19:0] PUL_ON0 = 20'(PUL_PERIOD_CYCLES / `FOG_DUTY_DIV0);
  localparam logic [19:0] PUL_ON1 = 20'(PUL_PERIOD_CYCLES / `FOG_DUTY_DIV1);
  localparam logic [19:0] PUL_ON2 = 20'(PUL_PERIOD_CYCLES / `FOG_DUTY_DIV2);
  localparam logic [19:0] PUL_ON3 = 20'(PUL_PERIOD_CYCLES / `FOG_DUTY_DIV3);

  fog_state_t  st;
  fog_state_t  next_st;
  fog_filt_if  filtBus ();
  logic [31:0] rdMux;
  logic [1:0]  wakeCap;
  logic [1:0]  wakeSet;
  logic [1:0]  wakeClr;
  logic [1:0]  wave;
  logic [19:0] pulOn;
  logic        foActive;
  logic        safeMode;
  logic        lvlMode;

  assign filtBus.raw = {pulsedPinIn, indPinIn};

  fog_level_filter #(
    .FILT_CYCLES (FILT_CYCLES)
  ) u_filter (
    .mclk  (mclk),
    .rst_n (rst_n),
    .f     (filtBus)
  );

  function automatic logic fog_valid_func(input logic [2:0] code);
    return code <= FOG_FN_HIGH;
  endfunction

  // Read multiplexer
  always_comb begin
    rdMux = 32'h00000000;
    if (address == `FOG_ADDR_PINFUNC) begin
      rdMux[`FOG_POS_FUNC_IND +: 3] = st.func[0];
      rdMux[`FOG_POS_FUNC_PUL +: 3] = st.func[1];
    end else if (address == `FOG_ADDR_FOCTRL) begin
      rdMux[`FOG_POS_FORCE]     = st.failForce;
      rdMux[`FOG_POS_DUTY +: 2] = st.duty;
    end else if (address == `FOG_ADDR_WAKESTAT) begin
      rdMux[1:0] = st.wakeStat;
    end else if (address == `FOG_ADDR_LEVEL) begin
      rdMux[1:0] = st.lvlStat;
    end else if (address == `FOG_ADDR_STATUS) begin
      rdMux[`FOG_POS_MODE +: 3] = powerMode;
      rdMux[`FOG_POS_FOACT]     = foActive;
    end
  end

  // Mode-derived qualifiers
  always_comb begin
    // A failure or the test force bit both light the fail role
    foActive = failActive | st.failForce;
    safeMode = (powerMode == FOG_MODE_RESTART) || (powerMode == FOG_MODE_FAILSAFE);
    lvlMode  = (powerMode == FOG_MODE_NORMAL) || (powerMode == FOG_MODE_STOP);
    case (st.duty)
      2'h0:    pulOn = PUL_ON0;
      2'h1:    pulOn = PUL_ON1;
      2'h2:    pulOn = PUL_ON2;
      default: pulOn = PUL_ON3;
    endcase
    wave[0] = st.indPhase;
    wave[1] = st.pulCnt < pulOn;
    for (int i = 0; i < 2; i++) begin
      // Wake sensing depends only on role and mode, so it returns after restart untouched
      wakeCap[i] = (st.func[i] == FOG_FN_WAKE) && (powerMode != FOG_MODE_FAILSAFE);
      wakeSet[i] = wakeCap[i] && (filtBus.filt[i] != st.prevLvl[i]);
    end
  end

  always_comb begin
    next_st = st;
    wakeClr = 2'h0;
    next_st.waitrequest = 1'b1;
    case (st.busState)
      FOG_BUS_IDLE: begin
        if (read || write) begin
          next_st.busState    = FOG_BUS_ACK;
          next_st.waitrequest = 1'b0;
          next_st.readdata    = rdMux;
        end
      end
      FOG_BUS_ACK: begin
        next_st.busState = FOG_BUS_IDLE;
        if (write && byteenable[0]) begin
          if (address == `FOG_ADDR_PINFUNC) begin
            // Outside normal mode the configuration is frozen
            if (powerMode == FOG_MODE_NORMAL) begin
              if (fog_valid_func(writedata[`FOG_POS_FUNC_IND +: 3])) begin
                next_st.func[0] = writedata[`FOG_POS_FUNC_IND +: 3];
              end
              if (fog_valid_func(writedata[`FOG_POS_FUNC_PUL +: 3])) begin
                next_st.func[1] = writedata[`FOG_POS_FUNC_PUL +: 3];
              end
            end
          end else if (address == `FOG_ADDR_FOCTRL) begin
            next_st.failForce = writedata[`FOG_POS_FORCE];
            next_st.duty      = writedata[`FOG_POS_DUTY +: 2];
          end else if (address == `FOG_ADDR_WAKESTAT) begin
            wakeClr = writedata[1:0];
          end
        end
      end
      default: begin
        next_st.busState = FOG_BUS_IDLE;
      end
    endcase

    // A wake event in the clearing cycle survives the clear
    next_st.wakeStat = (st.wakeStat & ~wakeClr) | wakeSet;
    next_st.prevLvl  = filtBus.filt;

    for (int i = 0; i < 2; i++) begin
      // Switch roles report too, giving feedback on the real output state
      if (lvlMode && (st.func[i] != FOG_FN_FAIL)) begin
        next_st.lvlStat[i] = filtBus.filt[i];
      end
    end
    // One bit serves both the pulsed pin level and the test level
    if (powerMode == FOG_MODE_INIT) begin
      next_st.lvlStat[1] = filtBus.filt[1];
    end

    // Waveforms restart on each activation so the first phase is whole
    if (!foActive) begin
      next_st.indCnt   = 26'h0000000;
      next_st.indPhase = 1'b1;
      next_st.pulCnt   = 20'h00000;
    end else begin
      if (st.indCnt == 26'(IND_HALF_CYCLES - 1)) begin
        next_st.indCnt   = 26'h0000000;
        next_st.indPhase = ~st.indPhase;
      end else begin
        next_st.indCnt = st.indCnt + 26'h0000001;
      end
      if (st.pulCnt == 20'(PUL_PERIOD_CYCLES - 1)) begin
        next_st.pulCnt = 20'h00000;
      end else begin
        next_st.pulCnt = st.pulCnt + 20'h00001;
      end
    end

    for (int i = 0; i < 2; i++) begin
      case (st.func[i])
        FOG_FN_FAIL: begin
          // Active-low open drain; reset default role
          next_st.pinOut[i] = 1'b0;
          next_st.pinOeN[i] = ~(foActive && wave[i]);
        end
        FOG_FN_LOW: begin
          next_st.pinOut[i] = 1'b0;
          next_st.pinOeN[i] = safeMode;
        end
        FOG_FN_HIGH: begin
          next_st.pinOut[i] = 1'b1;
          next_st.pinOeN[i] = safeMode;
        end
        default: begin
          next_st.pinOut[i] = 1'b0;
          next_st.pinOeN[i] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign readdata     = st.readdata;
  assign waitrequest  = st.waitrequest;
  assign indPinOut    = st.pinOut[0];
  assign indPinOeN    = st.pinOeN[0];
  assign pulsedPinOut = st.pinOut[1];
  assign pulsedPinOeN = st.pinOeN[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence cfgWriteAck;
    (st.busState == FOG_BUS_ACK) && write && byteenable[0] && (address == `FOG_ADDR_PINFUNC);
  endsequence

  sequence wakeEdgeSeen;
    (st.func[0] == FOG_FN_WAKE) && (powerMode != FOG_MODE_FAILSAFE) && (filtBus.filt[0] != st.prevLvl[0]);
  endsequence

  sequence lockedSwitch;
    (st.func[0] == FOG_FN_LOW || st.func[0] == FOG_FN_HIGH) && safeMode;
  endsequence

  reset_role_a: assert property ($rose(rst_n) |-> st.func == {FOG_FN_FAIL, FOG_FN_FAIL})
    else $error("pins not in fail role after reset");

  cfg_lock_a: assert property (cfgWriteAck and (powerMode != FOG_MODE_NORMAL) |=> $stable(st.func))
    else $error("function changed outside normal mode");

  cfg_take_a: assert property (cfgWriteAck and (powerMode == FOG_MODE_NORMAL)
                               and fog_valid_func(writedata[2:0]) |=> st.func[0] == $past(writedata[2:0]))
    else $error("function write in normal mode lost");

  wake_latch_a: assert property (wakeEdgeSeen |=> st.wakeStat[0])
    else $error("wake event not latched");

  wake_off_a: assert property ((powerMode == FOG_MODE_FAILSAFE) ##1 (powerMode == FOG_MODE_FAILSAFE)
                               |-> (st.wakeStat & ~$past(st.wakeStat)) == 2'h0)
    else $error("wake latched in fail-safe");

  switch_off_a: assert property (lockedSwitch ##1 lockedSwitch |-> st.pinOeN[0])
    else $error("switch driving in restart or fail-safe");

  switch_back_a: assert property ((st.func[1] == FOG_FN_HIGH) && (powerMode == FOG_MODE_NORMAL)
                                  |=> !st.pinOeN[1] && st.pinOut[1])
    else $error("high-side switch not resumed");

  off_quiet_a: assert property ((st.func[0] inside {FOG_FN_OFF, FOG_FN_WAKE}) |=> st.pinOeN[0])
    else $error("off or wake pin driving");

  // A drop of the fail signal resets the phase; only toggles made while lit are timed
  ind_toggle_a: assert property ($changed(st.indPhase) && $past(foActive) |->
                                 $past(st.indCnt) == 26'(IND_HALF_CYCLES - 1))
    else $error("indicator toggled off its half period");

  force_drive_a: assert property ((st.func[0] == FOG_FN_FAIL) && st.failForce && st.indPhase
                                  |=> !st.pinOeN[0])
    else $error("force bit did not drive indicator");

  level_rep_a: assert property ((powerMode == FOG_MODE_NORMAL) && (st.func[0] != FOG_FN_FAIL)
                                |=> st.lvlStat[0] == $past(filtBus.filt[0]))
    else $error("level status not updated");

  duty_dflt_a: assert property ($rose(rst_n) |-> st.duty == 2'h0)
    else $error("duty default not 20 percent");

  sequence pulseOnPhase;
    (st.func[1] == FOG_FN_FAIL) && foActive && (st.pulCnt < pulOn);
  endsequence

  pulse_drive_a: assert property (pulseOnPhase |=> !st.pinOeN[1] && !st.pinOut[1])
    else $error("pulsed fail output not driven in its on phase");

  pulse_idle_a: assert property ((st.func[1] == FOG_FN_FAIL) && !foActive |=> st.pinOeN[1])
    else $error("pulsed fail output driven with no failure");

  pulse_wrap_a: assert property (st.pulCnt < 20'(PUL_PERIOD_CYCLES))
    else $error("pulse counter beyond its period");

  test_level_a: assert property ((powerMode == FOG_MODE_INIT) |=> st.lvlStat[1] == $past(filtBus.filt[1]))
    else $error("test level not reported in init");

  // A stuck acknowledge would let one master request act twice
  ack_single_a: assert property (!st.waitrequest |=> st.waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule

/* File: verilog/fog_defines.svh */
`ifndef FOG_DEFINES_SVH
`define FOG_DEFINES_SVH

// Register byte addresses
`define FOG_ADDR_PINFUNC   8'h00
`define FOG_ADDR_FOCTRL    8'h04
`define FOG_ADDR_WAKESTAT  8'h08
`define FOG_ADDR_LEVEL     8'h0C
`define FOG_ADDR_STATUS    8'h10

// Field positions
`define FOG_POS_FUNC_IND   0
`define FOG_POS_FUNC_PUL   4
`define FOG_POS_FORCE      0
`define FOG_POS_DUTY       1
`define FOG_POS_MODE       0
`define FOG_POS_FOACT      3

// Reset values
`define FOG_RST_FUNC       3'h0
`define FOG_RST_FORCE      1'b0
`define FOG_RST_DUTY       2'h0
`define FOG_RST_LEVEL      2'h3

// Timing
`define FOG_CLK_HZ         100000000
`define FOG_IND_FREQ_CHZ   125
`define FOG_PUL_FREQ_HZ    100
`define FOG_FILT_TIME_US   64
`define FOG_IND_HALF_CYCLES ((`FOG_CLK_HZ / (`FOG_IND_FREQ_CHZ * 2)) * 100)
`define FOG_PUL_PERIOD_CYCLES (`FOG_CLK_HZ / `FOG_PUL_FREQ_HZ)
`define FOG_FILT_CYCLES    (`FOG_FILT_TIME_US * (`FOG_CLK_HZ / 1000000))

// Pulse duty divisors: 20, 10, 5 and 2.5 percent
`define FOG_DUTY_DIV0      5
`define FOG_DUTY_DIV1      10
`define FOG_DUTY_DIV2      20
`define FOG_DUTY_DIV3      40

`endif

/* File: verilog/fog_pkg.sv */
package fog_pkg;

  typedef enum logic [2:0] {
    FOG_MODE_INIT     = 3'h0,
    FOG_MODE_NORMAL   = 3'h1,
    FOG_MODE_STOP     = 3'h2,
    FOG_MODE_SLEEP    = 3'h3,
    FOG_MODE_RESTART  = 3'h4,
    FOG_MODE_FAILSAFE = 3'h5
  } fog_mode_t;

  typedef enum logic [2:0] {
    FOG_FN_FAIL = 3'h0,
    FOG_FN_OFF  = 3'h1,
    FOG_FN_WAKE = 3'h2,
    FOG_FN_LOW  = 3'h3,
    FOG_FN_HIGH = 3'h4
  } fog_func_t;

  typedef enum logic [1:0] {
    FOG_BUS_IDLE = 2'b00,
    FOG_BUS_ACK  = 2'b01
  } fog_bus_t;

endpackage

/* File: verilog/fog_filt_if.sv */
`timescale 1ns/1ns
interface fog_filt_if;
  logic [1:0] raw;
  logic [1:0] filt;
  modport src (output raw, input filt);
  modport flt (input raw, output filt);
endinterface

/* File: verilog/fog_level_filter.sv */
`timescale 1ns/1ns
`include "fog_defines.svh"
module fog_level_filter
  import fog_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = `FOG_FILT_CYCLES
) (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  // Pin levels
  fog_filt_if.flt    f
);

  typedef struct packed {
    logic [1:0][12:0] cnt;
    logic [1:0]       filt;
  } fog_filt_state_t;

  fog_filt_state_t st;
  fog_filt_state_t next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < 2; i++) begin
      if (f.raw[i] == st.filt[i]) begin
        next_st.cnt[i] = 13'h0000;
      end else if (st.cnt[i] == 13'(FILT_CYCLES - 1)) begin
        // Level accepted only after it held for the full filter time
        next_st.filt[i] = f.raw[i];
        next_st.cnt[i]  = 13'h0000;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 13'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{cnt: '0, filt: `FOG_RST_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign f.filt = st.filt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  filt_hold_a: assert property ($changed(st.filt[0]) |-> $past(st.cnt[0]) == 13'(FILT_CYCLES - 1))
    else $error("filtered level changed before filter time");
  filt_hold1_a: assert property ($changed(st.filt[1]) |-> $past(st.cnt[1]) == 13'(FILT_CYCLES - 1))
    else $error("filtered test level changed before filter time");

endmodule

/* File: dv/fog_load_model.sv */
`timescale 1ns/1ns
module fog_load_model (
  // Pin drivers of the block
  input  wire logic indOut,
  input  wire logic indOeN,
  input  wire logic pulOut,
  input  wire logic pulOeN,
  // Switch levels seen when nobody drives, 1 = open
  input  wire logic extInd,
  input  wire logic extPul,
  // Resolved pin levels
  output logic      indLvl,
  output logic      pulLvl
);
  // Both lines carry pull-ups, so a released line never keeps the driven value
  assign indLvl = !indOeN ? indOut : extInd;
  assign pulLvl = !pulOeN ? pulOut : extPul;
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`include "fog_defines.svh"
module tb_top;
  import fog_pkg::*;
  localparam int FILT = 4;
  localparam int PER  = 80;
  localparam int HALF = 8;
  logic        mclk       = 1'b0;
  logic        rst_n      = 1'b0;
  logic [7:0]  address    = 8'h00;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [31:0] writedata  = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  fog_mode_t   powerMode  = FOG_MODE_INIT;
  logic        failActive = 1'b0;
  logic        extInd     = 1'b1;
  logic        extPul     = 1'b1;
  logic        indOut, indOeN, pulOut, pulOeN, indLvl, pulLvl;
  logic [31:0] rdata;
  int          n_fail     = 0;
  int          checked    = 0;

  always #5 mclk = ~mclk;

  fog_gpio_ctrl #(.IND_HALF_CYCLES(HALF), .PUL_PERIOD_CYCLES(PER), .FILT_CYCLES(FILT)) u_fog_gpio_ctrl (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .powerMode(powerMode), .failActive(failActive),
    .indPinIn(indLvl), .indPinOut(indOut), .indPinOeN(indOeN),
    .pulsedPinIn(pulLvl), .pulsedPinOut(pulOut), .pulsedPinOeN(pulOeN));

  fog_load_model u_fog_load_model (.indOut(indOut), .indOeN(indOeN), .pulOut(pulOut), .pulOeN(pulOeN),
    .extInd(extInd), .extPul(extPul), .indLvl(indLvl), .pulLvl(pulLvl));

  task automatic stop_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Waitrequest and read data are registered, so the values read at the edge are those the edge samples
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_fail++;
      $display("BAD waitrequest expected 0 seen 1");
      stop_test();
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic bus_rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic set_mode(input fog_mode_t m);
    @(posedge mclk);
    powerMode <= m;
    cyc(3);
  endtask

  task automatic chk_oe(input logic [1:0] e);
    @(negedge mclk);
    chk("oe", {30'h0, e}, {30'h0, pulOeN, indOeN});
  endtask

  task automatic toggle;
    @(posedge mclk);
    extInd <= ~extInd;
    cyc(FILT + 4);
  endtask

  task automatic count_low(input bit pul, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if ((pul ? pulLvl : indLvl) === 1'b0) c++;
    end
  endtask

  task automatic t_reset;
    bus_rd(`FOG_ADDR_PINFUNC);
    chk("pinfunc", 32'h0, rdata);
    bus_rd(`FOG_ADDR_FOCTRL);
    chk("foctrl", 32'h0, rdata);
    bus_rd(8'h20);
    chk("unmapped", 32'h0, rdata);
    chk_oe(2'b11);
    bus_wr(`FOG_ADDR_PINFUNC, 32'h22);
    bus_rd(`FOG_ADDR_PINFUNC);
    chk("pinfunc init", 32'h0, rdata);
    @(posedge mclk);
    extPul <= 1'b0;
    cyc(FILT + 4);
    bus_rd(`FOG_ADDR_LEVEL);
    chk("test level", 32'h1, rdata);
    extPul <= 1'b1;
    cyc(FILT + 4);
    $display("test reset done");
  endtask

  task automatic t_fail;
    int c;
    set_mode(FOG_MODE_NORMAL);
    failActive <= 1'b1;
    set_mode(FOG_MODE_FAILSAFE);
    chk_oe(2'b00);
    set_mode(FOG_MODE_RESTART);
    chk_oe(2'b00);
    count_low(1'b0, 2 * HALF, c);
    chk("ind low", HALF, c);
    count_low(1'b1, PER, c);
    chk("pul low", PER / `FOG_DUTY_DIV0, c);
    set_mode(FOG_MODE_NORMAL);
    count_low(1'b0, 2 * HALF, c);
    chk("ind normal", HALF, c);
    bus_rd(`FOG_ADDR_STATUS);
    chk("status", 32'h9, rdata);
    bus_rd(`FOG_ADDR_PINFUNC);
    chk("pinfunc", 32'h0, rdata);
    failActive <= 1'b0;
    cyc(3);
    chk_oe(2'b11);
    $display("test fail done");
  endtask

  task automatic t_duty;
    int c;
    int div [4] = '{`FOG_DUTY_DIV0, `FOG_DUTY_DIV1, `FOG_DUTY_DIV2, `FOG_DUTY_DIV3};
    for (int d = 0; d < 4; d++) begin
      bus_wr(`FOG_ADDR_FOCTRL, 32'(d * 2 + 1));
      cyc(PER);
      count_low(1'b1, PER, c);
      chk("duty low", PER / div[d], c);
    end
    bus_wr(`FOG_ADDR_FOCTRL, 32'h0);
    cyc(3);
    chk_oe(2'b11);
    $display("test duty done");
  endtask

  task automatic t_switch;
    @(posedge mclk);
    extPul <= 1'b0;
    bus_wr(`FOG_ADDR_PINFUNC, 32'h43);
    cyc(FILT + 4);
    chk_oe(2'b00);
    bus_rd(`FOG_ADDR_LEVEL);
    chk("level sw", 32'h2, rdata);
    set_mode(FOG_MODE_STOP);
    chk_oe(2'b00);
    bus_wr(`FOG_ADDR_PINFUNC, 32'h11);
    bus_rd(`FOG_ADDR_LEVEL);
    chk("level stop", 32'h2, rdata);
    set_mode(FOG_MODE_RESTART);
    chk_oe(2'b11);
    set_mode(FOG_MODE_FAILSAFE);
    chk_oe(2'b11);
    set_mode(FOG_MODE_NORMAL);
    chk_oe(2'b00);
    bus_rd(`FOG_ADDR_PINFUNC);
    chk("pinfunc sw", 32'h43, rdata);
    extPul <= 1'b1;
    $display("test switch done");
  endtask

  task automatic t_wake;
    fog_mode_t   m [5] = '{FOG_MODE_STOP, FOG_MODE_SLEEP, FOG_MODE_RESTART, FOG_MODE_FAILSAFE, FOG_MODE_NORMAL};
    logic [31:0] e [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1};
    bus_wr(`FOG_ADDR_PINFUNC, 32'h22);
    // Releasing the switch drive is itself a level change: let it pass the filter first
    cyc(FILT + 4);
    bus_wr(`FOG_ADDR_WAKESTAT, 32'h3);
    @(posedge mclk);
    extPul <= 1'b0;
    cyc(FILT - 1);
    extPul <= 1'b1;
    cyc(FILT + 4);
    bus_rd(`FOG_ADDR_WAKESTAT);
    chk("wake glitch", 32'h0, rdata);
    foreach (m[i]) begin
      set_mode(FOG_MODE_NORMAL);
      bus_wr(`FOG_ADDR_WAKESTAT, 32'h3);
      set_mode(m[i]);
      toggle();
      bus_rd(`FOG_ADDR_WAKESTAT);
      chk("wake event", e[i], rdata);
      chk_oe(2'b11);
    end
    bus_rd(`FOG_ADDR_LEVEL);
    chk("level wake", 32'h2, rdata);
    bus_rd(`FOG_ADDR_PINFUNC);
    chk("pinfunc wake", 32'h22, rdata);
    toggle();
    $display("test wake done");
  endtask

  task automatic t_off;
    bus_wr(`FOG_ADDR_PINFUNC, 32'h11);
    bus_wr(`FOG_ADDR_WAKESTAT, 32'h3);
    toggle();
    bus_rd(`FOG_ADDR_WAKESTAT);
    chk("wake off", 32'h0, rdata);
    failActive <= 1'b1;
    set_mode(FOG_MODE_FAILSAFE);
    chk_oe(2'b11);
    @(posedge mclk);
    failActive <= 1'b0;
    set_mode(FOG_MODE_NORMAL);
    chk_oe(2'b11);
    $display("test off done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_fail();
    t_duty();
    t_switch();
    t_wake();
    t_off();
    stop_test();
  end
endmodule
